// ### rtl/swgc_pkg.sv
// shared constants and types of the switch global control block
package swgc_pkg;
   // register offsets on the plain register port
   localparam logic [7:0] ADDR_IDENT = 8'h00;
   localparam logic [7:0] ADDR_CTRL_ONE = 8'h02;
   // identity and run register field positions
   localparam int ID_FAMILY_LSB = 8;
   localparam int ID_CHIP_LSB = 4;
   localparam int ID_REV_LSB = 1;
   localparam int ID_RUN_BIT = 0;
   // control register one field positions
   localparam int CT_PASS_ALL = 15;
   localparam int CT_TX_PAUSE = 13;
   localparam int CT_RX_PAUSE = 12;
   localparam int CT_LEN_CHECK = 11;
   localparam int CT_AGE_EN = 10;
   localparam int CT_FAST_AGE = 9;
   localparam int CT_BACKOFF = 8;
   localparam int CT_PASS_PAUSE = 3;
   localparam int CT_LINK_AGE = 0;
   // values after reset
   localparam logic RUN_RESET = 1'b0;
   localparam logic [15:0] CTRL_ONE_RESET = 16'h3400;
   localparam logic [15:0] RDATA_RESET = 16'h0000;
   // length/type values below this are lengths that can be checked
   localparam logic [15:0] LEN_TYPE_LIMIT = 16'h05dc;
   // timing: printed figures and derived cycle counts
   localparam longint unsigned CLK_HZ = 64'd125_000_000;
   localparam longint unsigned FAST_AGE_US = 64'd800;
   localparam longint unsigned NORMAL_AGE_S = 64'd300;
   localparam longint unsigned NORMAL_AGE_TOL_S = 64'd75;
   localparam longint unsigned FAST_AGE_CYCLES = (FAST_AGE_US * CLK_HZ) / 64'd1_000_000;
   localparam longint unsigned NORMAL_AGE_CYCLES = NORMAL_AGE_S * CLK_HZ;
   localparam int AGE_CNT_W = 36;
   localparam logic [AGE_CNT_W-1:0] AGE_CNT_RESET = 36'h0_0000_0000;
   localparam int LINK_PORTS = 2;
   // aging mode, gray coded
   typedef enum logic [1:0] {
      AGE_NORMAL = 2'b00,
      AGE_FAST_ONCE = 2'b01
   } age_mode_t;
   // complete state of the control block
   typedef struct packed {
      logic run;
      logic [15:0] ctrl;
      logic [15:0] rdata;
      age_mode_t age_mode;
      logic [AGE_CNT_W-1:0] age_cnt;
      logic age_tick;
      logic age_flush;
      logic [LINK_PORTS-1:0] link_prev;
      logic pass_all;
      logic tx_pause_go;
      logic rx_pause_act;
      logic pause_fwd;
      logic frame_drop;
      logic backoff_aggr;
   } ctrl_state_t;
endpackage

// ### rtl/link_sync.sv
// three-stage pin synchroniser with agreement filter for link status
`timescale 1ns/1ps
`default_nettype none
module link_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   // all stages of the synchroniser in one word
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] filt;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   initial begin
      if (WIDTH < 1) begin
         $error("link_sync width must be at least one");
      end
   end

   // s1 feeds only s2; the filter looks at s2 and s3 alone
   always_comb begin
      next_st = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++) begin
         // a change counts once the two late stages agree
         if (st.s2[i] == st.s3[i]) begin
            next_st.filt[i] = st.s3[i];
         end
      end
   end

   // register the state, frozen while ce is low
   always_ff @(posedge clk) begin
      if (reset) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign q = st.filt;
endmodule
`default_nettype wire

// ### rtl/switch_global_control.sv
// global control, identity and address-aging timer of the two-port switch
//
// Overview of operation
// - identity register shows family, chip, revision fields
// - switching stays off until run bit set
// - pass-all forwards bad frames, sniffer mode only
// - transmit pause enable gates pause generation
// - receive pause enable gates reaction to pause
// - length check drops mismatching short frames
// - address aging runs only while enabled
// - fast age uses 800 microsecond period
// - aggressive back-off select for half duplex
// - pass-through forwards pause frames, else filtered
// - link loss triggers one fast age cycle
// - after fast cycle, return to normal period
// - any link loss flushes all learned addresses
`timescale 1ns/1ps
`default_nettype none
module switch_global_control #(
   parameter longint unsigned FAST_CYCLES = swgc_pkg::FAST_AGE_CYCLES,
   parameter longint unsigned NORMAL_CYCLES = swgc_pkg::NORMAL_AGE_CYCLES,
   // identity values: arbitrary neutral codes
   parameter logic [7:0] FAMILY_CODE = 8'h5a,
   parameter logic [3:0] CHIP_CODE = 4'h3,
   parameter logic [2:0] REV_CODE = 3'h2
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic CE,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire logic [swgc_pkg::LINK_PORTS-1:0] LINK_UP,
   input wire logic SNIFF_MODE,
   input wire logic FRAME_DONE,
   input wire logic [15:0] FRAME_LEN_FIELD,
   input wire logic [15:0] FRAME_BYTES,
   input wire logic PAUSE_TX_REQ,
   input wire logic PAUSE_RX_SEEN,
   output logic SWITCH_RUN,
   output logic PASS_ALL,
   output logic BACKOFF_AGGR,
   output logic TX_PAUSE_GO,
   output logic RX_PAUSE_ACT,
   output logic PAUSE_FWD,
   output logic FRAME_DROP,
   output logic AGE_TICK,
   output logic AGE_FLUSH,
   output logic FAST_AGE_ACTIVE
);
   // terminal counts of the age timer, one below each period
   localparam logic [swgc_pkg::AGE_CNT_W-1:0] FAST_LAST = swgc_pkg::AGE_CNT_W'(FAST_CYCLES - 64'd1);
   localparam logic [swgc_pkg::AGE_CNT_W-1:0] NORMAL_LAST = swgc_pkg::AGE_CNT_W'(NORMAL_CYCLES - 64'd1);

   swgc_pkg::ctrl_state_t st; // registered state
   swgc_pkg::ctrl_state_t next_st; // next state
   logic [swgc_pkg::LINK_PORTS-1:0] link_now; // filtered link status
   logic [swgc_pkg::LINK_PORTS-1:0] link_fall; // per-port link-down edge
   logic any_fall; // some port just lost link
   logic age_active; // timer may advance
   logic fast_period; // fast period selected
   logic [swgc_pkg::AGE_CNT_W-1:0] age_last; // terminal count in use
   logic [15:0] ident_word; // identity and run readback

   // refuse periods the timer cannot count
   initial begin
      if (FAST_CYCLES < 64'd1 || NORMAL_CYCLES < FAST_CYCLES) begin
         $error("age periods must satisfy 1 <= fast <= normal");
      end
      if (NORMAL_CYCLES > (64'd1 << swgc_pkg::AGE_CNT_W)) begin
         $error("normal age period exceeds timer width");
      end
   end

   // link pins come from outside the clock domain
   link_sync #(
      .WIDTH(swgc_pkg::LINK_PORTS)
   ) u_link_sync (
      .clk(CLK_SYS),
      .reset(RESET),
      .ce(CE),
      .d(LINK_UP),
      .q(link_now)
   );

   // link-down edges, seen on the filtered level only
   always_comb begin
      link_fall = st.link_prev & ~link_now;
      any_fall = |link_fall;
   end

   // readback of identity word; run bit is the only writable part
   always_comb begin
      ident_word = 16'h0000;
      ident_word[swgc_pkg::ID_FAMILY_LSB +: 8] = FAMILY_CODE;
      ident_word[swgc_pkg::ID_CHIP_LSB +: 4] = CHIP_CODE;
      ident_word[swgc_pkg::ID_REV_LSB +: 3] = REV_CODE;
      ident_word[swgc_pkg::ID_RUN_BIT] = st.run;
   end

   // age timer period selection
   always_comb begin
      age_active = st.run & st.ctrl[swgc_pkg::CT_AGE_EN];
      fast_period = st.ctrl[swgc_pkg::CT_FAST_AGE] | (st.age_mode == swgc_pkg::AGE_FAST_ONCE);
      age_last = fast_period ? FAST_LAST : NORMAL_LAST;
   end

   // next-state logic: register port, gating of switch functions, age timer
   always_comb begin
      next_st = st;
      next_st.rdata = swgc_pkg::RDATA_RESET;
      next_st.age_tick = 1'b0;
      next_st.age_flush = 1'b0;
      next_st.link_prev = link_now;
      // register writes; reserved control bits are plain storage
      if (WR) begin
         if (ADDR == swgc_pkg::ADDR_IDENT) begin
            next_st.run = WDATA[swgc_pkg::ID_RUN_BIT];
         end else if (ADDR == swgc_pkg::ADDR_CTRL_ONE) begin
            next_st.ctrl = WDATA;
         end
      end
      // register reads answer in the next cycle, unmapped reads give zero
      if (RD) begin
         if (ADDR == swgc_pkg::ADDR_IDENT) begin
            next_st.rdata = ident_word;
         end else if (ADDR == swgc_pkg::ADDR_CTRL_ONE) begin
            next_st.rdata = st.ctrl;
         end
      end
      next_st.pass_all = st.run & st.ctrl[swgc_pkg::CT_PASS_ALL] & SNIFF_MODE;
      next_st.backoff_aggr = st.run & st.ctrl[swgc_pkg::CT_BACKOFF];
      next_st.tx_pause_go = st.run & st.ctrl[swgc_pkg::CT_TX_PAUSE] & PAUSE_TX_REQ;
      next_st.rx_pause_act = st.run & st.ctrl[swgc_pkg::CT_RX_PAUSE] & PAUSE_RX_SEEN;
      next_st.pause_fwd = st.run & st.ctrl[swgc_pkg::CT_PASS_PAUSE] & PAUSE_RX_SEEN;
      next_st.frame_drop = st.run & st.ctrl[swgc_pkg::CT_LEN_CHECK] & FRAME_DONE
         & (FRAME_LEN_FIELD < swgc_pkg::LEN_TYPE_LIMIT) & (FRAME_LEN_FIELD != FRAME_BYTES);
      // flush table on any link loss
      if (any_fall) begin
         next_st.age_flush = 1'b1;
      end
      // age timer: holds its count while aging is off
      if (age_active) begin
         if (st.age_cnt >= age_last) begin
            next_st.age_cnt = swgc_pkg::AGE_CNT_RESET;
            next_st.age_tick = 1'b1;
            next_st.age_mode = swgc_pkg::AGE_NORMAL;
         end else begin
            next_st.age_cnt = st.age_cnt + 36'h0_0000_0001;
         end
      end
      // link loss starts one fast cycle; restarts the count so it is a full short cycle
      if (any_fall && st.ctrl[swgc_pkg::CT_LINK_AGE]) begin
         next_st.age_mode = swgc_pkg::AGE_FAST_ONCE;
         next_st.age_cnt = swgc_pkg::AGE_CNT_RESET;
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         st <= '0;
         st.run <= swgc_pkg::RUN_RESET;
         st.ctrl <= swgc_pkg::CTRL_ONE_RESET;
         st.age_mode <= swgc_pkg::AGE_NORMAL;
         st.age_cnt <= swgc_pkg::AGE_CNT_RESET;
      end else if (CE) begin
         st <= next_st;
      end
   end

   // all outputs straight from the state register
   assign RDATA = st.rdata;
   assign SWITCH_RUN = st.run;
   assign PASS_ALL = st.pass_all;
   assign BACKOFF_AGGR = st.backoff_aggr;
   assign TX_PAUSE_GO = st.tx_pause_go;
   assign RX_PAUSE_ACT = st.rx_pause_act;
   assign PAUSE_FWD = st.pause_fwd;
   assign FRAME_DROP = st.frame_drop;
   assign AGE_TICK = st.age_tick;
   assign AGE_FLUSH = st.age_flush;
   assign FAST_AGE_ACTIVE = st.age_mode == swgc_pkg::AGE_FAST_ONCE;

   // identity read returns the fixed codes in the next cycle
   property p_ident_read;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && RD && ADDR == swgc_pkg::ADDR_IDENT)
         |=> (RDATA[15:1] == {FAMILY_CODE, CHIP_CODE, REV_CODE}) && (RDATA[0] == SWITCH_RUN);
   endproperty
   a_ident_read: assert property (p_ident_read) else $error("identity readback wrong");

   // a run-bit write shows on the run output one cycle later
   property p_run_write;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && WR && ADDR == swgc_pkg::ADDR_IDENT) |=> (SWITCH_RUN == $past(WDATA[0]));
   endproperty
   a_run_write: assert property (p_run_write) else $error("run bit not taken");

   // no switch function output other than the link-loss flush while stopped
   property p_stopped_quiet;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && !SWITCH_RUN) |=> !(TX_PAUSE_GO || RX_PAUSE_ACT || FRAME_DROP || PASS_ALL || AGE_TICK
         || PAUSE_FWD || BACKOFF_AGGR);
   endproperty
   a_stopped_quiet: assert property (p_stopped_quiet) else $error("activity while stopped");

   // pass-all never without sniffer mode
   property p_pass_all;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && !SNIFF_MODE) |=> !PASS_ALL;
   endproperty
   a_pass_all: assert property (p_pass_all) else $error("pass-all without sniffer");

   // transmit pause enable off means no pause generated
   property p_tx_pause;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && !st.ctrl[swgc_pkg::CT_TX_PAUSE]) |=> !TX_PAUSE_GO;
   endproperty
   a_tx_pause: assert property (p_tx_pause) else $error("pause sent while disabled");

   // receive pause honoured when enabled and running
   property p_rx_pause;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && SWITCH_RUN && PAUSE_RX_SEEN) |=> (RX_PAUSE_ACT == $past(st.ctrl[swgc_pkg::CT_RX_PAUSE]));
   endproperty
   a_rx_pause: assert property (p_rx_pause) else $error("receive pause gate wrong");

   // a drop only ever follows a checked, short, mismatching frame
   property p_frame_drop;
      @(posedge CLK_SYS) disable iff (RESET)
      $rose(FRAME_DROP) |-> $past(FRAME_DONE && st.ctrl[swgc_pkg::CT_LEN_CHECK]
         && FRAME_LEN_FIELD < swgc_pkg::LEN_TYPE_LIMIT && FRAME_LEN_FIELD != FRAME_BYTES);
   endproperty
   a_frame_drop: assert property (p_frame_drop) else $error("spurious frame drop");

   // with aging disabled and no link loss the timer neither ticks nor moves
   property p_age_off;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && !st.ctrl[swgc_pkg::CT_AGE_EN] && !any_fall) |=> !AGE_TICK && $stable(st.age_cnt);
   endproperty
   a_age_off: assert property (p_age_off) else $error("aging while disabled");

   // in fast mode the count never passes the fast terminal count
   property p_fast_bound;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && st.ctrl[swgc_pkg::CT_FAST_AGE] && st.age_cnt <= FAST_LAST) |=> (st.age_cnt <= FAST_LAST);
   endproperty
   a_fast_bound: assert property (p_fast_bound) else $error("fast period overrun");

   // link loss with link-change aging enters the fast cycle
   property p_link_fast;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && any_fall && st.ctrl[swgc_pkg::CT_LINK_AGE]) |=> FAST_AGE_ACTIVE && st.age_cnt == '0;
   endproperty
   a_link_fast: assert property (p_link_fast) else $error("link loss fast age missed");

   // a tick ends the triggered fast cycle
   property p_back_normal;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && next_st.age_tick && !any_fall) |=> !FAST_AGE_ACTIVE && AGE_TICK;
   endproperty
   a_back_normal: assert property (p_back_normal) else $error("no return to normal aging");

   // every link loss flushes the table on the next cycle
   property p_flush;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && any_fall) |=> AGE_FLUSH;
   endproperty
   a_flush: assert property (p_flush) else $error("no flush on link loss");

   // pass-all follows its enable while running in sniffer mode
   property p_pass_all_on;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && SWITCH_RUN && st.ctrl[swgc_pkg::CT_PASS_ALL] && SNIFF_MODE) |=> PASS_ALL;
   endproperty
   a_pass_all_on: assert property (p_pass_all_on) else $error("pass-all not applied");

   // back-off select mirrors its control bit, only while running
   property p_backoff;
      @(posedge CLK_SYS) disable iff (RESET)
      CE |=> (BACKOFF_AGGR == $past(SWITCH_RUN && st.ctrl[swgc_pkg::CT_BACKOFF]));
   endproperty
   a_backoff: assert property (p_backoff) else $error("back-off select wrong");

   // received pause frames pass only with pass-through set, else filtered
   property p_pause_fwd;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && PAUSE_RX_SEEN) |=> (PAUSE_FWD == $past(SWITCH_RUN && st.ctrl[swgc_pkg::CT_PASS_PAUSE]));
   endproperty
   a_pause_fwd: assert property (p_pause_fwd) else $error("pause pass-through wrong");

   // read data stand for one cycle only, zero when no read was made
   property p_rdata_idle;
      @(posedge CLK_SYS) disable iff (RESET)
      (CE && !RD) |=> (RDATA == swgc_pkg::RDATA_RESET);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ### test/switch_global_control_bench.sv
// self-checking register-level bench for the switch global control block
`timescale 1ns/1ps
`default_nettype none
module switch_global_control_bench;
   // shortened age periods keep the run short
   localparam longint unsigned FAST = 4;
   localparam longint unsigned NORM = 16;
   // identity codes: arbitrary values handed to the design
   localparam logic [7:0] FAM = 8'h5a;
   localparam logic [3:0] CHIP = 4'h3;
   localparam logic [2:0] REV = 3'h2;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic [1:0] link_up = 2'b00;
   logic sniff_mode = 1'b0;
   logic frame_done = 1'b0;
   logic [15:0] len_field = 16'h0000;
   logic [15:0] frame_bytes = 16'h0000;
   logic tx_req = 1'b0;
   logic rx_seen = 1'b0;
   logic switch_run, pass_all, backoff_aggr, tx_pause_go, rx_pause_act;
   logic pause_fwd, frame_drop, age_tick, age_flush, fast_age_active;
   int err_count = 0;
   int n_tests = 0;
   int gap;
   logic found;

   switch_global_control #(.FAST_CYCLES(FAST), .NORMAL_CYCLES(NORM), .FAMILY_CODE(FAM), .CHIP_CODE(CHIP),
      .REV_CODE(REV)) u_dut (.CLK_SYS(clk_sys), .RESET(reset), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .LINK_UP(link_up), .SNIFF_MODE(sniff_mode), .FRAME_DONE(frame_done),
      .FRAME_LEN_FIELD(len_field), .FRAME_BYTES(frame_bytes), .PAUSE_TX_REQ(tx_req), .PAUSE_RX_SEEN(rx_seen),
      .SWITCH_RUN(switch_run), .PASS_ALL(pass_all), .BACKOFF_AGGR(backoff_aggr), .TX_PAUSE_GO(tx_pause_go),
      .RX_PAUSE_ACT(rx_pause_act), .PAUSE_FWD(pause_fwd), .FRAME_DROP(frame_drop), .AGE_TICK(age_tick),
      .AGE_FLUSH(age_flush), .FAST_AGE_ACTIVE(fast_age_active));

   // free-running system clock, 8 ns period
   always #4 clk_sys = ~clk_sys;

   // compare one value and count it
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one-cycle write strobe; ends settled after the edge
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      #1;
   endtask

   // one-cycle read strobe; data looked at in the following cycle only
   task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp, input string name);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      chk(name, rdata, exp);
   endtask

   // pause request and pause receipt together; all three gated results checked
   task automatic pause_case(input logic tx_exp, input logic rx_exp, input logic fwd_exp);
      @(posedge clk_sys);
      tx_req <= 1'b1;
      rx_seen <= 1'b1;
      @(posedge clk_sys);
      tx_req <= 1'b0;
      rx_seen <= 1'b0;
      #1;
      chk("tx_pause_go", {15'h0, tx_pause_go}, {15'h0, tx_exp});
      chk("rx_pause_act", {15'h0, rx_pause_act}, {15'h0, rx_exp});
      chk("pause_fwd", {15'h0, pause_fwd}, {15'h0, fwd_exp});
   endtask

   // end-of-frame strobe with its length field and real length
   task automatic frame_case(input logic [15:0] f, input logic [15:0] b, input logic exp);
      @(posedge clk_sys);
      frame_done <= 1'b1;
      len_field <= f;
      frame_bytes <= b;
      @(posedge clk_sys);
      frame_done <= 1'b0;
      #1;
      chk("frame_drop", {15'h0, frame_drop}, {15'h0, exp});
   endtask

   // bounded wait for the flush (which=0) or tick (which=1) pulse
   task automatic wait_hi(input int which, input int lim, output logic hit);
      int k;
      hit = 1'b0;
      for (k = 0; k < lim && !hit; k++) begin
         @(posedge clk_sys);
         #1;
         hit = (which == 0) ? (age_flush === 1'b1) : (age_tick === 1'b1);
      end
   endtask

   // cycles from one age tick to the next
   task automatic tick_gap(output int g);
      logic hit;
      wait_hi(1, 200, hit);
      g = 0;
      hit = 1'b0;
      while (!hit && g < 200) begin
         @(posedge clk_sys);
         #1;
         g++;
         hit = (age_tick === 1'b1);
      end
   endtask

   task automatic test_end(input string name);
      $display("test %s done", name);
   endtask

   // counts, verdict and end of run
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // watchdog: the sequence needs a few thousand cycles at most
   initial begin
      #40000;
      err_count++;
      report_and_stop();
   end

   // main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      // values after reset, switch still stopped
      rd_reg(8'h00, {FAM, CHIP, REV, 1'b0}, "ident");
      rd_reg(8'h02, 16'h3400, "ctrl_one");
      @(posedge clk_sys);
      #1;
      chk("rdata_idle", rdata, 16'h0000);
      pause_case(1'b0, 1'b0, 1'b0);
      chk("switch_run", {15'h0, switch_run}, 16'h0000);
      test_end("reset");
      // identity bits ignore writes, run bit follows; unmapped place refused
      wr_reg(8'h00, 16'hffff);
      rd_reg(8'h00, {FAM, CHIP, REV, 1'b1}, "ident_run");
      chk("switch_run", {15'h0, switch_run}, 16'h0001);
      wr_reg(8'h02, 16'hffff);
      rd_reg(8'h02, 16'hffff, "ctrl_one_rw");
      wr_reg(8'h04, 16'h1234);
      rd_reg(8'h04, 16'h0000, "unmapped");
      // strobes with the clock enable low are ignored
      @(posedge clk_sys);
      ce <= 1'b0;
      wr_reg(8'h02, 16'h0000);
      @(posedge clk_sys);
      ce <= 1'b1;
      rd_reg(8'h02, 16'hffff, "ce_frozen");
      test_end("registers");
      // pause enables gate generation, reaction and pass-through
      wr_reg(8'h02, 16'h3008);
      pause_case(1'b1, 1'b1, 1'b1);
      wr_reg(8'h02, 16'h2000);
      pause_case(1'b1, 1'b0, 1'b0);
      wr_reg(8'h02, 16'h1000);
      pause_case(1'b0, 1'b1, 1'b0);
      test_end("pause");
      // length check, including the 1500 boundary
      wr_reg(8'h02, 16'h0800);
      frame_case(16'h0040, 16'h0041, 1'b1);
      frame_case(16'h0040, 16'h0040, 1'b0);
      frame_case(16'h05db, 16'h0010, 1'b1);
      frame_case(16'h05dc, 16'h0010, 1'b0);
      wr_reg(8'h02, 16'h0000);
      frame_case(16'h0040, 16'h0041, 1'b0);
      test_end("length");
      // pass-all needs sniffer mode; aggressive back-off select
      wr_reg(8'h02, 16'h8100);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("pass_all", {15'h0, pass_all}, 16'h0000);
      chk("backoff", {15'h0, backoff_aggr}, 16'h0001);
      @(posedge clk_sys);
      sniff_mode <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("pass_all", {15'h0, pass_all}, 16'h0001);
      wr_reg(8'h02, 16'h0000);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("pass_all", {15'h0, pass_all}, 16'h0000);
      chk("backoff", {15'h0, backoff_aggr}, 16'h0000);
      @(posedge clk_sys);
      sniff_mode <= 1'b0;
      test_end("pass_all");
      // normal and fast periods, then aging switched off
      wr_reg(8'h02, 16'h3400);
      tick_gap(gap);
      chk("normal_gap", 16'(gap), 16'(NORM));
      wr_reg(8'h02, 16'h3600);
      tick_gap(gap);
      chk("fast_gap", 16'(gap), 16'(FAST));
      wr_reg(8'h02, 16'h3000);
      wait_hi(1, 40, found);
      chk("age_off", {15'h0, found}, 16'h0000);
      test_end("aging");
      // link rise flushes nothing; link loss flushes and runs one fast cycle
      wr_reg(8'h02, 16'h3401);
      @(posedge clk_sys);
      link_up <= 2'b11;
      wait_hi(0, 12, found);
      chk("flush_rise", {15'h0, found}, 16'h0000);
      @(posedge clk_sys);
      link_up <= 2'b10;
      wait_hi(0, 12, found);
      chk("flush_loss", {15'h0, found}, 16'h0001);
      chk("fast_active", {15'h0, fast_age_active}, 16'h0001);
      wait_hi(1, 6, found);
      chk("fast_tick", {15'h0, found}, 16'h0001);
      @(posedge clk_sys);
      #1;
      chk("fast_done", {15'h0, fast_age_active}, 16'h0000);
      tick_gap(gap);
      chk("back_normal", 16'(gap), 16'(NORM));
      // without link-change aging a loss still flushes, but no fast cycle
      wr_reg(8'h02, 16'h3400);
      @(posedge clk_sys);
      link_up <= 2'b00;
      wait_hi(0, 12, found);
      chk("flush_plain", {15'h0, found}, 16'h0001);
      chk("no_fast", {15'h0, fast_age_active}, 16'h0000);
      test_end("link");
      report_and_stop();
   end
endmodule
`default_nettype wire
